// *** ccs_params.svh ***
// register offsets, field positions and reset values of the clock select block
`ifndef CCS_PARAMS_SVH
`define CCS_PARAMS_SVH

`define CCS_OFF_PLL_SEL      12'h000
`define CCS_OFF_PLL_UPD      12'h004
`define CCS_OFF_MAIN_SEL     12'h008
`define CCS_OFF_MAIN_UPD     12'h00C
`define CCS_OFF_OUT_SEL      12'h010
`define CCS_OFF_OUT_UPD      12'h014
`define CCS_OFF_OUT_DIV      12'h018
`define CCS_OFF_PIN_CFG      12'h01C
`define CCS_OFF_STATUS       12'h020

`define CCS_RST_SEL          2'h0
`define CCS_RST_UPD          1'h1
`define CCS_RST_DIV          8'h00
`define CCS_RST_PIN_CFG      16'h0010
// writable bits of the pin configuration, bits 9:7 stay zero
`define CCS_PIN_CFG_MASK     16'hFC7F

`define CCS_PF_PIN_FUNCTION_HI       2
`define CCS_PF_PIN_FUNCTION_LO       0
`define CCS_PF_PULL_HI       4
`define CCS_PF_PULL_LO       3
`define CCS_PF_HYS           5
`define CCS_PF_INV           6
`define CCS_PF_OD            10
`define CCS_PF_FILT_HI       12
`define CCS_PF_FILT_LO       11
`define CCS_PF_FDIV_HI       15
`define CCS_PF_FDIV_LO       13

`define CCS_FDIV_RESERVED    3'h7

`endif

// *** ccs_pkg.sv ***
// types shared by the clock source select block
package ccs_pkg;

    typedef enum logic [1:0] {
        CCS_PULL_NONE,
        CCS_PULL_DOWN,
        CCS_PULL_UP,
        CCS_PULL_REPEAT
    } ccs_pull_t;

    typedef enum logic [2:0] {
        CCS_FN_GPIO,
        CCS_FN_CLOCK_OUTPUT_PIN,
        CCS_FN_TIMER,
        CCS_FN_USB
    } ccs_pin_function_t;

    // sampled levels of the source oscillators
    typedef struct packed {
        logic internal_rc_oscillator;
        logic crystal_system_oscillator;
        logic wdt;
        logic pll_out;
        logic clk32k;
    } ccs_src_t;

    // pad configuration outputs
    typedef struct packed {
        logic pull_up;
        logic pull_down;
        logic repeater;
        logic hysteresis;
    } ccs_pad_cfg_t;

    typedef struct packed {
        logic [1:0] act;
        logic [1:0] nxt;
        logic       pend;
        logic       hold;
        logic       out;
    } ccs_mux_state_t;

    typedef struct packed {
        ccs_src_t    s1;
        ccs_src_t    s2;
        logic        pin1;
        logic        pin2;
        logic [1:0]  pll_sel;
        logic [1:0]  main_sel;
        logic [1:0]  out_sel;
        logic        pll_upd;
        logic        main_upd;
        logic        out_upd;
        logic [7:0]  div;
        logic [15:0] pcfg;
        logic [31:0] rdata;
        logic        err;
        logic [7:0]  cnt;
        logic        co_prev;
        logic        co;
        logic        fsamp;
        logic [1:0]  fcnt;
        logic        fval;
        logic        pad_out;
        logic        pad_oe_n;
    } ccs_state_t;

endpackage : ccs_pkg

// *** ccs_glitch_free_mux.sv ***
// four-way glitch-free clock switch working on sampled clock levels
`timescale 1ns/1ps
module ccs_glitch_free_mux
    import ccs_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [3:0] src,
    input  wire logic [3:0] legal,
    input  wire logic [1:0] sel,
    input  wire logic       update,
    output logic            clk_out,
    output logic [1:0]      active_sel
);
    ccs_mux_state_t st;
    ccs_mux_state_t next_st;

    // a reserved code yields a quiet low output
    function automatic logic lvl(input logic [3:0] s, input logic [3:0] l, input logic [1:0] i);
        lvl = s[i] & l[i];
    endfunction : lvl

    always_comb begin
        next_st = st;
        if (update) begin
            next_st.pend = 1'b1;
            next_st.nxt  = sel;
        end
        if (st.pend) begin
            // park low once the old source is low, then wait for the new one to be low
            if (!st.hold) begin
                if (!lvl(src, legal, st.act)) begin
                    next_st.hold = 1'b1;
                end
            end else if (!lvl(src, legal, st.nxt) && !update) begin
                next_st.act  = st.nxt;
                next_st.pend = 1'b0;
                next_st.hold = 1'b0;
            end
        end
        next_st.out = (st.pend && (st.hold || !lvl(src, legal, st.act))) ? 1'b0
                    : lvl(src, legal, st.act);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign clk_out    = st.out;
    assign active_sel = st.act;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_no_silent_switch: assert property (!st.pend |=> $stable(st.act))
        else $error("mux source changed without an update");
    a_switch_while_low: assert property (!$stable(st.act) |-> !st.out && $past(!st.out))
        else $error("mux switched while output high");
    a_update_latched: assert property (update |=> st.pend && st.nxt == $past(sel))
        else $error("update not latched");
    c_switch_done: cover property (st.pend ##[1:20] !st.pend);
endmodule : ccs_glitch_free_mux

// *** ccs_clock_select.sv ***
// clock source multiplexers, clock output divider and clock output pin logic
// Overview of operation
// - The main clock select is two bits, resets to 0, and picks internal RC, PLL input, watchdog oscillator or PLL output.
// - The clock output select is two bits, resets to 0, and picks internal RC, crystal, watchdog oscillator or main clock.
// - The eight-bit clock output divider resets to 0, where 0 stops the output, 1 passes it and N divides by N.
// - The PLL reference select is two bits, resets to 0, and picks internal RC, crystal, nothing or the 32 kHz clock.
// - The PLL reference update bit resets to 1, writing 0 changes nothing and writing 1 applies the new source.
// - The main clock update bit resets to 1, writing 0 changes nothing and writing 1 adopts the programmed source.
// - The clock output update bit resets to 1, writing 0 changes nothing and writing 1 adopts the programmed source.
// - The pin function field is three bits, resets to 0, and picks GPIO, clock output, timer match or USB toggle, else nothing.
// - The pull field at bits 4:3 resets to pull-up and picks none, pull-down, pull-up or repeater.
// - With the invert bit 6 set a high pin reads as 0, with it clear a high pin reads as 1.
// - Open-drain enable sits at bit 10 and hysteresis at bit 5, both reset to 0, and bits 9:7 read as 0.
// - The filter field at bits 12:11 resets to bypass and otherwise needs 1, 2 or 3 stable sampling ticks.
// - The sampling clock field at bits 15:13 resets to 0, picks divider 0 to 6, and code 7 is reserved.
`timescale 1ns/1ps
`include "ccs_params.svh"
module ccs_clock_select
    import ccs_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire ccs_src_t    src_clk,
    input  wire logic [6:0]  filter_tick,
    input  wire logic        gpio_out,
    input  wire logic        gpio_oe_n,
    input  wire logic        timer32_match_output,
    input  wire logic        usb_frame_toggle,
    input  wire logic        pad_in,
    output logic             pad_out,
    output logic             pad_oe_n,
    output ccs_pad_cfg_t     pad_cfg,
    output logic             gpio_in,
    output logic             main_clk,
    output logic             pll_in_clk,
    output logic             clock_output_pin
);
    ccs_state_t st;
    ccs_state_t next_st;

    logic       wr;
    logic       rd_setup;
    logic       pll_go;
    logic       main_go;
    logic       out_go;
    logic       mux_co;
    logic [1:0] pll_act;
    logic [1:0] main_act;
    logic [1:0] out_act;
    logic       hit;
    logic       tick;
    logic       raw;
    logic       src_rise;
    logic       drive_val;
    logic       drive_n;
    logic [1:0] fmode;

    assign wr       = psel && penable && pwrite;
    assign rd_setup = psel && !penable;
    // any write with bit 0 set applies the source, so a 0-then-1 sequence also works
    assign pll_go   = wr && paddr == `CCS_OFF_PLL_UPD && pwdata[0];
    assign main_go  = wr && paddr == `CCS_OFF_MAIN_UPD && pwdata[0];
    assign out_go   = wr && paddr == `CCS_OFF_OUT_UPD && pwdata[0];

    // code 2 of the PLL reference is reserved and gives no clock
    ccs_glitch_free_mux u_pll_mux (
        .pclk       (pclk),
        .presetn    (presetn),
        .src        ({st.s2.clk32k, 1'b0, st.s2.crystal_system_oscillator, st.s2.internal_rc_oscillator}),
        .legal      (4'hB),
        .sel        (st.pll_sel),
        .update     (pll_go),
        .clk_out    (pll_in_clk),
        .active_sel (pll_act)
    );

    ccs_glitch_free_mux u_main_mux (
        .pclk       (pclk),
        .presetn    (presetn),
        .src        ({st.s2.pll_out, st.s2.wdt, pll_in_clk, st.s2.internal_rc_oscillator}),
        .legal      (4'hF),
        .sel        (st.main_sel),
        .update     (main_go),
        .clk_out    (main_clk),
        .active_sel (main_act)
    );

    ccs_glitch_free_mux u_out_mux (
        .pclk       (pclk),
        .presetn    (presetn),
        .src        ({main_clk, st.s2.wdt, st.s2.crystal_system_oscillator, st.s2.internal_rc_oscillator}),
        .legal      (4'hF),
        .sel        (st.out_sel),
        .update     (out_go),
        .clk_out    (mux_co),
        .active_sel (out_act)
    );

    always_comb begin
        next_st = st;
        hit     = 1'b1;
        fmode   = st.pcfg[`CCS_PF_FILT_HI:`CCS_PF_FILT_LO];
        // pin-side inputs pass two flip-flops before use
        next_st.s1   = src_clk;
        next_st.s2   = st.s1;
        next_st.pin1 = pad_in;
        next_st.pin2 = st.pin1;

        if (wr) begin
            case (paddr)
                `CCS_OFF_PLL_SEL:  next_st.pll_sel  = pwdata[1:0];
                `CCS_OFF_PLL_UPD:  next_st.pll_upd  = pwdata[0];
                `CCS_OFF_MAIN_SEL: next_st.main_sel = pwdata[1:0];
                `CCS_OFF_MAIN_UPD: next_st.main_upd = pwdata[0];
                `CCS_OFF_OUT_SEL:  next_st.out_sel  = pwdata[1:0];
                `CCS_OFF_OUT_UPD:  next_st.out_upd  = pwdata[0];
                `CCS_OFF_OUT_DIV:  next_st.div      = pwdata[7:0];
                `CCS_OFF_PIN_CFG:  next_st.pcfg     = pwdata[15:0] & `CCS_PIN_CFG_MASK;
                default: ;
            endcase
        end

        // read data is captured in the setup cycle so prdata comes from a flop
        if (rd_setup) begin
            next_st.rdata = '0;
            case (paddr)
                `CCS_OFF_PLL_SEL:  next_st.rdata[1:0]  = st.pll_sel;
                `CCS_OFF_PLL_UPD:  next_st.rdata[0]    = st.pll_upd;
                `CCS_OFF_MAIN_SEL: next_st.rdata[1:0]  = st.main_sel;
                `CCS_OFF_MAIN_UPD: next_st.rdata[0]    = st.main_upd;
                `CCS_OFF_OUT_SEL:  next_st.rdata[1:0]  = st.out_sel;
                `CCS_OFF_OUT_UPD:  next_st.rdata[0]    = st.out_upd;
                `CCS_OFF_OUT_DIV:  next_st.rdata[7:0]  = st.div;
                `CCS_OFF_PIN_CFG:  next_st.rdata[15:0] = st.pcfg;
                `CCS_OFF_STATUS:   next_st.rdata[6:0]  = {st.fval, out_act, main_act, pll_act};
                default:           hit = 1'b0;
            endcase
            // writes to unmapped offsets are dropped without an error response
            next_st.err = !hit && !pwrite;
        end

        // divider counts rising edges of the selected output source
        src_rise       = mux_co && !st.co_prev;
        next_st.co_prev = mux_co;
        if (st.div == 8'h00) begin
            next_st.cnt = 8'h00;
            next_st.co  = 1'b0;
        end else if (st.div == 8'h01) begin
            next_st.cnt = 8'h00;
            next_st.co  = mux_co;
        end else begin
            if (src_rise) begin
                next_st.cnt = (st.cnt >= st.div - 8'h01) ? 8'h00 : st.cnt + 8'h01;
            end
            next_st.co = next_st.cnt < (st.div >> 1);
        end

        // sampling tick from the chosen pin-configuration divider, none for the reserved code
        tick = (st.pcfg[`CCS_PF_FDIV_HI:`CCS_PF_FDIV_LO] == `CCS_FDIV_RESERVED) ? 1'b0
             : filter_tick[st.pcfg[`CCS_PF_FDIV_HI:`CCS_PF_FDIV_LO]];
        raw = st.pin2 ^ st.pcfg[`CCS_PF_INV];
        if (fmode == 2'h0) begin
            next_st.fsamp = raw;
            next_st.fcnt  = 2'h0;
            next_st.fval  = raw;
        end else if (tick) begin
            if (raw != st.fsamp) begin
                next_st.fsamp = raw;
                next_st.fcnt  = 2'h1;
            end else if (st.fcnt != 2'h3) begin
                next_st.fcnt = st.fcnt + 2'h1;
            end
            if (next_st.fcnt >= fmode) begin
                next_st.fval = next_st.fsamp;
            end
        end

        drive_val = 1'b0;
        drive_n   = 1'b1;
        case (st.pcfg[`CCS_PF_PIN_FUNCTION_HI:`CCS_PF_PIN_FUNCTION_LO])
            CCS_FN_GPIO: begin
                drive_val = gpio_out;
                drive_n   = gpio_oe_n;
            end
            CCS_FN_CLOCK_OUTPUT_PIN: begin
                drive_val = st.co;
                drive_n   = 1'b0;
            end
            CCS_FN_TIMER: begin
                drive_val = timer32_match_output;
                drive_n   = 1'b0;
            end
            CCS_FN_USB: begin
                drive_val = usb_frame_toggle;
                drive_n   = 1'b0;
            end
            default: ;
        endcase
        // open drain only ever pulls low; a high level releases the pad
        if (st.pcfg[`CCS_PF_OD]) begin
            next_st.pad_out  = 1'b0;
            next_st.pad_oe_n = drive_n || drive_val;
        end else begin
            next_st.pad_out  = drive_val;
            next_st.pad_oe_n = drive_n;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st          <= '0;
            st.pll_sel  <= `CCS_RST_SEL;
            st.main_sel <= `CCS_RST_SEL;
            st.out_sel  <= `CCS_RST_SEL;
            st.pll_upd  <= `CCS_RST_UPD;
            st.main_upd <= `CCS_RST_UPD;
            st.out_upd  <= `CCS_RST_UPD;
            st.div      <= `CCS_RST_DIV;
            st.pcfg     <= `CCS_RST_PIN_CFG;
            st.pad_oe_n <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign prdata             = st.rdata;
    assign pready             = psel && penable;
    assign pslverr            = psel && penable && st.err;
    assign pad_out            = st.pad_out;
    assign pad_oe_n           = st.pad_oe_n;
    assign gpio_in            = st.fval;
    assign clock_output_pin   = st.co;
    assign pad_cfg.pull_up    = st.pcfg[`CCS_PF_PULL_HI:`CCS_PF_PULL_LO] == CCS_PULL_UP;
    assign pad_cfg.pull_down  = st.pcfg[`CCS_PF_PULL_HI:`CCS_PF_PULL_LO] == CCS_PULL_DOWN;
    assign pad_cfg.repeater   = st.pcfg[`CCS_PF_PULL_HI:`CCS_PF_PULL_LO] == CCS_PULL_REPEAT;
    assign pad_cfg.hysteresis = st.pcfg[`CCS_PF_HYS];

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_main_sel_write: assert property (
        wr && paddr == `CCS_OFF_MAIN_SEL |=> st.main_sel == $past(pwdata[1:0]))
        else $error("main select write lost");
    a_out_sel_write: assert property (
        wr && paddr == `CCS_OFF_OUT_SEL |=> st.out_sel == $past(pwdata[1:0]))
        else $error("output select write lost");
    a_div_zero_quiet: assert property ((st.div == 8'h00)[*2] |-> !st.co)
        else $error("divider zero but output toggles");
    a_div_one_pass: assert property ((st.div == 8'h01)[*2] |-> st.co == $past(mux_co))
        else $error("divide by one not passing source");
    a_pll_sel_write: assert property (
        wr && paddr == `CCS_OFF_PLL_SEL |=> st.pll_sel == $past(pwdata[1:0]))
        else $error("pll reference write lost");
    a_pin_function_release: assert property (
        st.pcfg[`CCS_PF_PIN_FUNCTION_HI] && !st.pcfg[`CCS_PF_OD] |=> pad_oe_n)
        else $error("unused function still drives pad");
    a_pull_decode: assert property (
        $onehot0({pad_cfg.pull_up, pad_cfg.pull_down, pad_cfg.repeater}))
        else $error("pull controls overlap");
    a_invert_bypass: assert property (
        fmode == 2'h0 && $stable(fmode) |=> gpio_in == ($past(st.pin2) ^ $past(st.pcfg[6])))
        else $error("bypassed input value wrong");
    a_open_drain_low: assert property (st.pcfg[`CCS_PF_OD] |=> !pad_out || pad_oe_n)
        else $error("open drain drives high");
    a_filter_hold: assert property (fmode != 2'h0 && !tick |=> $stable(st.fval))
        else $error("filter changed without a tick");
    a_reserved_tick: assert property (
        st.pcfg[15:13] == `CCS_FDIV_RESERVED && fmode != 2'h0 |=> $stable(st.fval))
        else $error("reserved sampling clock changed filter");
    a_reserved_zero: assert property (
        rd_setup && paddr == `CCS_OFF_PIN_CFG |=> prdata[31:16] == 16'h0000 && prdata[9:7] == 3'h0)
        else $error("reserved bits read nonzero");

    c_clock_output_pin_pin: cover property (st.pcfg[2:0] == 3'h1 && st.div == 8'h02 && st.co ##[1:50] !st.co);
    c_main_update: cover property (main_go ##[1:40] $changed(main_act));
    c_filter_take: cover property (fmode == 2'h3 && $changed(st.fval));
endmodule : ccs_clock_select

// *** ccs_osc_model.sv ***
// oscillator levels and pad wire on the far side of the clock select block
`timescale 1ns/1ps
module ccs_osc_model
    import ccs_pkg::*;
(
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         pad_out,
    input  wire logic         pad_oe_n,
    input  wire ccs_pad_cfg_t pad_cfg,
    input  wire logic         ext_drive,
    input  wire logic         ext_level,
    output ccs_src_t          src_clk,
    output logic              pad_in
);
    logic [7:0] tick;
    logic       junk;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick <= 8'h00;
            junk <= 1'b0;
        end else begin
            tick <= tick + 8'h01;
            junk <= ~junk;
        end
    end
    // distinct rates so every switch crosses edges of two different sources
    assign src_clk.internal_rc_oscillator     = tick[1];
    assign src_clk.crystal_system_oscillator  = tick[2];
    assign src_clk.wdt     = tick[3];
    assign src_clk.pll_out = tick[0];
    assign src_clk.clk32k  = tick[4];
    // a released wire floats to its pull, otherwise it wanders every cycle
    assign pad_in = !pad_oe_n ? pad_out : ext_drive ? ext_level :
                    pad_cfg.pull_up ? 1'b1 : pad_cfg.pull_down ? 1'b0 : junk;
endmodule : ccs_osc_model

// *** clock_source_select_clock_output_pin_bench.sv ***
// self-checking bench of the clock select block with a register model
`timescale 1ns/1ps
module clock_source_select_clock_output_pin_bench;
    import ccs_pkg::*;
    logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0]  paddr;
    logic [31:0]  pwdata, prdata;
    ccs_src_t     src_clk;
    ccs_pad_cfg_t pad_cfg;
    logic [6:0]   filter_tick;
    logic         gpio_out, gpio_oe_n, tmr, usb, pad_in, pad_out, pad_oe_n, gpio_in;
    logic         main_clk, pll_in_clk, clock_output_pin, ext_drive, ext_level, prev_lvl;
    int           num_errors, total_checks, n, seed;
    int           model[8];
    int           act[3];
    int           mask[8] = '{3, 1, 3, 1, 3, 1, 255, 32'h0000_fc7f};
    int           rstv[8] = '{0, 1, 0, 1, 0, 1, 0, 32'h0000_0010};

    ccs_clock_select u_ccs_clock_select (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .src_clk(src_clk), .filter_tick(filter_tick),
        .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n), .timer32_match_output(tmr),
        .usb_frame_toggle(usb), .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
        .pad_cfg(pad_cfg), .gpio_in(gpio_in), .main_clk(main_clk), .pll_in_clk(pll_in_clk),
        .clock_output_pin(clock_output_pin));
    ccs_osc_model u_ccs_osc_model (.pclk(pclk), .presetn(presetn), .pad_out(pad_out),
        .pad_oe_n(pad_oe_n), .pad_cfg(pad_cfg), .ext_drive(ext_drive),
        .ext_level(ext_level), .src_clk(src_clk), .pad_in(pad_in));

    always #5 pclk = ~pclk;
    always @(posedge pclk) begin
        filter_tick <= 7'($random(seed));
        tmr         <= 1'($random(seed));
        usb         <= 1'($random(seed));
    end

    task automatic results;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : results

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // holds the request until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only the watchdog ends a wait for pready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input int i, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, 12'(i * 4), d, q, e);
        model[i] = d & mask[i];
        if (i % 2 == 1 && i < 6 && d[0])
            act[i / 2] = model[i - 1];
    endtask : wr

    task automatic rd(input int i, input logic experr);
        logic [31:0] q;
        logic        e;
        apb(1'b0, 12'(i * 4), 32'h0000_0000, q, e);
        check("slverr", 32'(e), 32'(experr));
        check("rdata", q, experr ? 32'h0000_0000 : 32'(model[i]));
    endtask : rd

    // the mux needs edges of both sources, so the active code is polled
    task automatic settle;
        logic [31:0] q;
        logic        e;
        logic [5:0]  x;
        int          k;
        x = {2'(act[2]), 2'(act[1]), 2'(act[0])};
        k = 0;
        do begin
            apb(1'b0, 12'h020, 32'h0000_0000, q, e);
            k++;
        end while (q[5:0] !== x && k < 100);
        check("active", 32'(q[5:0]), 32'(x));
    endtask : settle

    task automatic rise(output int m);
        logic p;
        m = 0;
        do begin
            p = clock_output_pin;
            @(posedge pclk);
            m++;
        end while (!(p === 1'b0 && clock_output_pin === 1'b1) && m < 300);
    endtask : rise

    task automatic pad_chk(input logic [31:0] cfg, input logic gout, input logic lvl);
        wr(7, cfg);
        gpio_out  <= gout;
        ext_level <= lvl;
        repeat (8) @(posedge pclk);
    endtask : pad_chk

    initial begin
        #500000;
        num_errors++;
        results();
    end

    initial begin
        pclk = 0;
        presetn = 0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {filter_tick, tmr, usb, gpio_out, ext_drive, ext_level} = '0;
        gpio_oe_n = 1;
        seed = 32'h115e_8b53;
        num_errors = 0;
        total_checks = 0;
        act = '{0, 0, 0};
        model = rstv;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 8; i++) rd(i, 1'b0);
        rd(9, 1'b1);
        for (int i = 0; i < 8; i++) begin
            wr(i, $random(seed));
            rd(i, 1'b0);
        end
        settle();
        // 32 kHz main clock reached through the pll input path, pll reference switched to 32 kHz first
        wr(0, 32'h0000_0003);
        wr(1, 32'h0000_0000);
        wr(1, 32'h0000_0001);
        wr(2, 32'h0000_0001);
        wr(3, 32'h0000_0000);
        settle();
        wr(3, 32'h0000_0001);
        settle();
        for (int c = 3; c >= 0; c--) begin
            wr(4, c);
            wr(5, 32'h0000_0000);
            wr(5, 32'h0000_0001);
            settle();
        end
        for (int c = 0; c < 4; c++) begin
            wr(2, c);
            wr(3, 32'h0000_0001);
            settle();
        end
        // main now runs from the fastest source, the pll input from the 32 kHz one
        prev_lvl = main_clk;
        repeat (4) begin
            @(posedge pclk);
            check("main clk", 32'(main_clk), 32'(!prev_lvl));
            prev_lvl = main_clk;
        end
        prev_lvl = pll_in_clk;
        n = 0;
        repeat (64) begin
            @(posedge pclk);
            n += int'(pll_in_clk && !prev_lvl);
            prev_lvl = pll_in_clk;
        end
        check("pll in rises", 32'(n), 32'd2);
        wr(7, 32'h0000_0001);
        wr(6, 32'h0000_0004);
        rise(n);
        rise(n);
        check("div4 period", 32'(n), 32'd16);
        // the pad stage adds one register behind the divided clock
        @(posedge pclk);
        check("pad follows clock_output_pin", 32'(pad_out), 32'(clock_output_pin));
        wr(6, 32'h0000_0001);
        rise(n);
        rise(n);
        check("div1 period", 32'(n), 32'd4);
        wr(6, 32'h0000_0000);
        repeat (10) @(posedge pclk);
        rise(n);
        check("div0 silent", 32'(n), 32'd300);
        for (int p = 0; p < 4; p++) begin
            wr(7, (p << 3) | ((p & 1) << 5));
            check("pad cfg", 32'(pad_cfg), {p == 2, p == 1, p == 3, 1'(p & 1)});
        end
        gpio_oe_n <= 1'b0;
        pad_chk(32'h0000_0000, 1'b1, 1'b0);
        check("gpio drive", 32'({pad_out, pad_oe_n}), 32'h0000_0002);
        pad_chk(32'h0000_0004, 1'b1, 1'b0);
        check("released", 32'(pad_oe_n), 32'h0000_0001);
        pad_chk(32'h0000_0400, 1'b1, 1'b0);
        check("od high", 32'(pad_oe_n), 32'h0000_0001);
        pad_chk(32'h0000_0400, 1'b0, 1'b0);
        check("od low", 32'({pad_out, pad_oe_n}), 32'h0000_0000);
        for (int f = 2; f < 4; f++) begin
            pad_chk(32'(f), 1'b0, 1'b0);
            prev_lvl = (f == 2) ? tmr : usb;
            @(posedge pclk);
            check("pin_function drive", 32'({pad_out, pad_oe_n}), 32'({prev_lvl, 1'b0}));
        end
        gpio_oe_n <= 1'b1;
        ext_drive <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            pad_chk((k & 2) << 5, 1'b0, 1'(k));
            check("gpio in", 32'(gpio_in), 32'(k[0] ^ k[1]));
        end
        pad_chk(32'h0000_e800, 1'b0, 1'b1);
        repeat (20) @(posedge pclk);
        // the filter froze low in the write cycle while the pin now sits high
        check("frozen filter", 32'(gpio_in), 32'h0000_0000);
        pad_chk(32'h0000_e800, 1'b0, 1'b0);
        pad_chk(32'h0000_1800, 1'b0, 1'b1);
        repeat (30) @(posedge pclk);
        check("filter 3", 32'(gpio_in), 32'h0000_0001);
        results();
    end
endmodule : clock_source_select_clock_output_pin_bench
